/* logic/arop_port.sv */
`timescale 1ns/1ns
`include "arop_regs.svh"
// Operation
// - parallel mode drives pins as result bits 7-10
// - external clock serial turns pin into chain input
// - chain level reaches output after 16 periods
// - internal clock, readmode high: read during conversion
// - internal clock, readmode low: read after conversion
// - serial select high sends result serially
// - result held in shift register, msb first
// - format select picks binary or twos complement
// - internal clock data stable on both edges
// - external clock, no inversion: change on rise, host samples fall
// - external clock, inversion: change on fall, host samples rise
// - clock pin direction follows clock source select
// - format low inverts msb for twos complement
// - internal source drives clock, external uses host clock
// - clock inversion applies in master and slave
// - internal clock frame sync marks valid data
module arop_port (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic conv_busy_in,
  input wire logic conv_done_in,
  input wire logic [15:0] conv_result_in,
  input wire logic [15:0] data_pin_in,
  output logic [15:0] data_pin_out,
  output logic [15:0] data_pin_oe_n_out
);

  logic rst_q1; // first reset release stage
  logic rst_n; // released reset used everywhere else
  arop_pkg::arop_pin_pair_t pin_lvl; // filtered chain and clock pin levels
  logic [`AROP_CTRL_W-1:0] ctrl; // software configuration
  logic [15:0] result_q; // latest raw conversion result
  logic [15:0] shreg; // output shift register
  logic [3:0] bit_cnt; // bits shifted in current frame
  arop_pkg::arop_state_t state; // frame state
  logic busy_prev; // busy delayed for edge find
  logic sclk_prev; // previous effective external clock level
  logic chain_cap; // chain bit caught on the host sampling edge
  logic sclk_raw; // internal clock before inversion
  logic [7:0] q_cnt; // quarter-period counter
  logic [1:0] phase; // quarter index in an internal period

  // decoded configuration
  logic ser_mode;
  logic ext_clk;
  logic inv_clk;
  logic fmt_bin;
  logic sync_pol;
  logic chain_lvl;
  logic sclk_eff;
  logic act_edge;
  logic smp_edge;
  logic conv_start;
  logic int_master;
  logic int_start;
  logic q_tick;
  logic [15:0] fmt_result;
  logic [15:0] fmt_new;
  logic [15:0] load_word;
  logic apb_access;
  logic addr_ok;

  // reset released through two flops, asserted at once
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // pins from the host are asynchronous to our clock
  arop_sync3 u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .d_in({data_pin_in[`AROP_PIN_SCLK], data_pin_in[`AROP_PIN_CHAIN]}),
    .lvl_out(pin_lvl)
  );

  assign ser_mode = ctrl[`AROP_CTRL_SER];
  assign ext_clk = ctrl[`AROP_CTRL_EXT];
  assign inv_clk = ctrl[`AROP_CTRL_INV];
  assign fmt_bin = ctrl[`AROP_CTRL_FMT];
  assign sync_pol = ctrl[`AROP_CTRL_SPOL];
  assign chain_lvl = pin_lvl[0]; // readmode in master mode, chain data in slave
  // inversion folded in so the active edge is always a rise here
  assign sclk_eff = pin_lvl[1] ^ inv_clk;
  assign act_edge = ser_mode & ext_clk & sclk_eff & ~sclk_prev;
  assign smp_edge = ser_mode & ext_clk & ~sclk_eff & sclk_prev;
  assign conv_start = conv_busy_in & ~busy_prev;
  assign int_master = ser_mode & ~ext_clk;
  // read during conversion sends the previous result at start
  assign int_start = int_master & (chain_lvl ? conv_start : conv_done_in);
  assign q_tick = (q_cnt == 8'(`AROP_SCLK_QUARTER - 1));

  // output code: msb inverted when format select is low
  assign fmt_result = {result_q[15] ^ ~fmt_bin, result_q[14:0]};
  assign fmt_new = {conv_result_in[15] ^ ~fmt_bin, conv_result_in[14:0]};
  assign load_word = conv_done_in ? fmt_new : fmt_result;

  // apb decode
  assign apb_access = psel_in & penable_in & pready_out;
  assign addr_ok = (paddr_in == `AROP_OFF_CTRL) | (paddr_in == `AROP_OFF_STATUS) |
                   (paddr_in == `AROP_OFF_RESULT);

  // edge-find history
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      busy_prev <= 1'b0;
      sclk_prev <= 1'b0;
    end else begin
      busy_prev <= conv_busy_in;
      sclk_prev <= sclk_eff;
    end
  end

  // result latch at end of conversion
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= 16'h0000;
    end else if (conv_done_in) begin
      result_q <= conv_result_in;
    end
  end

  // chain data caught on the edge where the host samples
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      chain_cap <= 1'b0;
    end else if (smp_edge) begin
      chain_cap <= chain_lvl;
    end
  end

  // frame sequencer, shift register and bit count
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= arop_pkg::AROP_IDLE;
      shreg <= 16'h0000;
      bit_cnt <= 4'h0;
    end else if (!ser_mode) begin
      // parallel mode keeps the serial side parked
      state <= arop_pkg::AROP_IDLE;
      bit_cnt <= 4'h0;
    end else if (ext_clk) begin
      if (conv_done_in) begin
        // new result puts its msb on the line before the first edge
        state <= arop_pkg::AROP_SHIFT;
        shreg <= fmt_new;
        bit_cnt <= 4'h0;
      end else if (act_edge) begin
        unique case (state)
          arop_pkg::AROP_IDLE: begin
            shreg <= shreg;
          end
          arop_pkg::AROP_SHIFT: begin
            // chain bits enter at the bottom, surface after sixteen shifts
            shreg <= {shreg[14:0], chain_cap};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `AROP_LAST_BIT) begin
              state <= arop_pkg::AROP_PASS;
            end
          end
          arop_pkg::AROP_PASS: begin
            // downstream results keep flowing through
            shreg <= {shreg[14:0], chain_cap};
          end
        endcase
      end else if (smp_edge && state != arop_pkg::AROP_IDLE) begin
        // chain level fills the slot freed by the last shift, so the
        // first upstream bit is not lost to a stale capture
        shreg[0] <= chain_lvl;
      end
    end else begin
      if (int_start) begin
        state <= arop_pkg::AROP_SHIFT;
        shreg <= load_word;
        bit_cnt <= 4'h0;
      end else if (state == arop_pkg::AROP_SHIFT && q_tick && phase == 2'h3) begin
        // end of a period: next bit changes only while clock is low
        shreg <= {shreg[14:0], 1'b0};
        bit_cnt <= bit_cnt + 4'h1;
        if (bit_cnt == `AROP_LAST_BIT) begin
          state <= arop_pkg::AROP_IDLE;
        end
      end else if (state == arop_pkg::AROP_PASS) begin
        // chaining needs an external clock
        state <= arop_pkg::AROP_IDLE;
      end
    end
  end

  // internal clock generator in quarter periods
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      q_cnt <= 8'h00;
      phase <= 2'h0;
      sclk_raw <= 1'b0;
    end else if (!int_master || int_start || state != arop_pkg::AROP_SHIFT) begin
      // clock idles low between frames and restarts aligned to data
      q_cnt <= 8'h00;
      phase <= 2'h0;
      sclk_raw <= 1'b0;
    end else if (q_tick) begin
      q_cnt <= 8'h00;
      phase <= phase + 2'h1;
      // rise a quarter after data changes, fall a quarter before next
      if (phase == 2'h0) begin
        sclk_raw <= 1'b1;
      end else if (phase == 2'h2) begin
        sclk_raw <= 1'b0;
      end
    end else begin
      q_cnt <= q_cnt + 8'h01;
    end
  end

  // shared pin drive, all registered
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      data_pin_out <= 16'h0000;
      data_pin_oe_n_out <= 16'hffff;
    end else if (!ser_mode) begin
      // whole bus driven with the formatted result
      data_pin_out <= fmt_result;
      data_pin_oe_n_out <= 16'h0000;
    end else begin
      data_pin_out <= fmt_result;
      // low bits become select inputs or float
      data_pin_oe_n_out <= {5'h00, 4'h0, 7'h7f};
      data_pin_oe_n_out[`AROP_PIN_CHAIN] <= 1'b1;
      data_pin_out[`AROP_PIN_SERIAL_RESULT_OUT] <= shreg[15];
      data_pin_oe_n_out[`AROP_PIN_SERIAL_RESULT_OUT] <= 1'b0;
      data_pin_out[`AROP_PIN_SCLK] <= sclk_raw ^ inv_clk;
      data_pin_oe_n_out[`AROP_PIN_SCLK] <= ext_clk;
      // sync only framed with the internal clock, else parked inactive
      data_pin_out[`AROP_PIN_SYNC] <= (int_master & (state == arop_pkg::AROP_SHIFT)) ^ sync_pol;
      data_pin_oe_n_out[`AROP_PIN_SYNC] <= 1'b0;
    end
  end

  // control register write, byte lane zero only
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `AROP_CTRL_RST;
    end else if (apb_access && pwrite_in && paddr_in == `AROP_OFF_CTRL && pstrb_in[0]) begin
      ctrl <= pwdata_in[`AROP_CTRL_W-1:0];
    end
  end

  // one wait state so read data can come from a flop
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~addr_ok;
    end
  end

  // read data mux, captured in the wait cycle
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      prdata_out <= 32'h00000000;
    end else if (psel_in && penable_in && !pready_out && !pwrite_in) begin
      prdata_out <= 32'h00000000;
      if (paddr_in == `AROP_OFF_CTRL) begin
        prdata_out[`AROP_CTRL_W-1:0] <= ctrl;
      end else if (paddr_in == `AROP_OFF_STATUS) begin
        prdata_out[`AROP_ST_ACTIVE] <= (state != arop_pkg::AROP_IDLE);
        prdata_out[`AROP_ST_PASS] <= (state == arop_pkg::AROP_PASS);
        prdata_out[`AROP_ST_CNT_HI:`AROP_ST_CNT_LO] <= bit_cnt;
      end else if (paddr_in == `AROP_OFF_RESULT) begin
        prdata_out[15:0] <= fmt_result;
      end
    end
  end

endmodule

/* include/arop_regs.svh */
`ifndef AROP_REGS_SVH
`define AROP_REGS_SVH

// apb register byte offsets
`define AROP_OFF_CTRL 8'h00
`define AROP_OFF_STATUS 8'h04
`define AROP_OFF_RESULT 8'h08

// control register field positions
`define AROP_CTRL_SER 0
`define AROP_CTRL_EXT 1
`define AROP_CTRL_INV 2
`define AROP_CTRL_FMT 3
`define AROP_CTRL_SPOL 4
`define AROP_CTRL_W 5
// reset: parallel, internal clock, no inversion, straight binary, sync active high
`define AROP_CTRL_RST 5'h08

// status register field positions
`define AROP_ST_ACTIVE 0
`define AROP_ST_PASS 1
`define AROP_ST_CNT_LO 4
`define AROP_ST_CNT_HI 7

// shared pin positions on the 16-bit data bus
`define AROP_PIN_CHAIN 7
`define AROP_PIN_SERIAL_RESULT_OUT 8
`define AROP_PIN_SCLK 9
`define AROP_PIN_SYNC 10
`define AROP_PIN_LOW_HI 6

// result framing
`define AROP_RESULT_BITS 16
`define AROP_LAST_BIT 4'hf

// internal shift clock timing
`define AROP_CLK_PERIOD_NS 20
`define AROP_SCLK_PERIOD_NS 160
`define AROP_SCLK_QUARTER ((`AROP_SCLK_PERIOD_NS / `AROP_CLK_PERIOD_NS) / 4)

`endif

/* include/arop_pkg.sv */
package arop_pkg;

  // serial frame state, one-hot
  typedef enum logic [2:0] {
    AROP_IDLE  = 3'h1,
    AROP_SHIFT = 3'h2,
    AROP_PASS  = 3'h4
  } arop_state_t;

  // two pins that are read back from the shared bus
  typedef logic [1:0] arop_pin_pair_t;

endpackage

/* logic/arop_sync3.sv */
`timescale 1ns/1ns
// three-stage synchroniser with agreement filter, one lane per bit
module arop_sync3 (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire arop_pkg::arop_pin_pair_t d_in,
  output arop_pkg::arop_pin_pair_t lvl_out
);

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_lane
      logic s1; // metastable stage, read only by s2
      logic s2;
      logic s3;
      // plain three-flop chain
      always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
        end else begin
          s1 <= d_in[i];
          s2 <= s1;
          s3 <= s2;
        end
      end
      // a change counts only once two late stages agree
      always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          lvl_out[i] <= 1'b0;
        end else if (s2 == s3) begin
          lvl_out[i] <= s2;
        end
      end
    end
  endgenerate

endmodule

/* tb/arop_port_sva.sv */
`timescale 1ns/1ns
// pin and apb checks, seen from the top ports only
module arop_port_sva (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [15:0] data_pin_out,
  input wire logic [15:0] data_pin_oe_n_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  // serial port with the clock pin driven out: master mode
  wire logic ser_int;
  assign ser_int = data_pin_oe_n_out[7] & ~data_pin_oe_n_out[9];
  property p_rdy_pulse;
    pready_out |=> !pready_out;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held too long");
  property p_rdy_cause;
    pready_out |-> $past(psel_in && penable_in);
  endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("pready without access");
  property p_rdy_bound;
    psel_in && penable_in && !pready_out |-> ##[1:2] pready_out;
  endproperty
  a_rdy_bound: assert property (p_rdy_bound) else $error("pready late");
  // unmapped read: error flag and zero data
  property p_err_map;
    psel_in && penable_in && pready_out && !pwrite_in && paddr_in > 8'h08 |-> pslverr_out && prdata_out == 32'h0;
  endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped read not refused");
  property p_par_pins;
    !data_pin_oe_n_out[0] |-> data_pin_oe_n_out == 16'h0;
  endproperty
  a_par_pins: assert property (p_par_pins) else $error("parallel bus not fully driven");
  // pin 15 driven excludes the reset state
  property p_ser_pins;
    data_pin_oe_n_out[7] && !data_pin_oe_n_out[15] |-> data_pin_oe_n_out[6:0] == 7'h7f && data_pin_oe_n_out[8:8] == 1'b0;
  endproperty
  a_ser_pins: assert property (p_ser_pins) else $error("serial pin directions wrong");
  // data bit set two cycles before any clock edge
  property p_int_stable;
    ser_int && $stable(data_pin_oe_n_out) && $changed(data_pin_out[9]) |-> $past(data_pin_out[8], 2) == data_pin_out[8];
  endproperty
  a_int_stable: assert property (p_int_stable) else $error("data moved near clock edge");
  property p_sync_hold;
    ser_int && $stable(data_pin_oe_n_out) && $rose(data_pin_out[10]) |=> data_pin_out[10] [*8];
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("frame sync too short");
endmodule

bind arop_port arop_port_sva u_arop_port_sva (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .paddr_in(paddr_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .data_pin_out(data_pin_out),
  .data_pin_oe_n_out(data_pin_oe_n_out));

/* tb/arop_host_model.sv */
`timescale 1ns/1ns
// host clocking results out in slave mode, chain source behind
module arop_host_model (
  input wire logic sdo_in,
  input wire logic inv_in,
  output logic sclk_out,
  output logic chain_out
);
  logic ph;
  // clock idles at the inversion level outside frames
  assign sclk_out = inv_in ^ ph;
  initial begin
    ph = 1'b0;
    chain_out = 1'b0;
  end
  // short active phase: sample before the late update lands
  // chain bit moves mid active phase so it never races either clock edge
  task automatic run(input logic [15:0] pat, output logic [31:0] cap);
    cap = '0;
    chain_out = 1'b0;
    #7;
    for (int k = 1; k <= 32; k++) begin
      ph = 1'b1;
      #30;
      chain_out = (k <= 16) ? pat[16 - k] : ~chain_out;
      #30;
      ph = 1'b0;
      cap = {cap[30:0], sdo_in};
      #100;
    end
    chain_out = ~chain_out;
  endtask
endmodule

/* tb/arop_port_tb.sv */
`timescale 1ns/1ns
// bench for the result output port
module arop_port_tb;
  logic clk, nrst, psel, pen, pwr, busy, done, rm, ext_md, inv, pready, perr, e, m_sclk, m_chain;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, cap;
  logic [15:0] res, pout, poe_n, pin, v;
  int err_total, comparisons;
  // wire level: device where driving, else the far side
  assign pin = (pout & ~poe_n) | (poe_n & {6'h0, m_sclk, 1'b0, ext_md ? m_chain : rm, 7'h0});
  arop_port u_arop_port (.sys_clk_in(clk), .nrst_in(nrst), .paddr_in(paddr), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .pwdata_in(pwdata), .pstrb_in(4'hf), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(perr), .conv_busy_in(busy), .conv_done_in(done), .conv_result_in(res), .data_pin_in(pin),
    .data_pin_out(pout), .data_pin_oe_n_out(poe_n));
  arop_host_model u_arop_host_model (.sdo_in(pin[8]), .inv_in(inv), .sclk_out(m_sclk), .chain_out(m_chain));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // conversion with a raw result
  task automatic conv(input logic [15:0] r);
    @(posedge clk);
    busy <= 1'b1;
    repeat (4) @(posedge clk);
    busy <= 1'b0;
    done <= 1'b1;
    res <= r;
    @(posedge clk);
    done <= 1'b0;
  endtask
  // master mode: take data at each rising clock pin
  task automatic cap_int(output logic [15:0] o);
    int n, i;
    logic p;
    n = 0;
    i = 0;
    o = '0;
    p = pout[9];
    while (i < 16 && n < 3000) begin
      @(negedge clk);
      n++;
      if (!p && pout[9]) begin
        o = {o[14:0], pout[8]};
        i++;
      end
      p = pout[9];
    end
  endtask
  function automatic logic [15:0] fmt(input logic [15:0] r, input logic sb);
    return sb ? r : r ^ 16'h8000;
  endfunction
  initial begin
    {psel, pen, pwr, busy, done, rm, ext_md, inv} = '0;
    paddr = '0;
    pwdata = '0;
    res = '0;
    err_total = 0;
    comparisons = 0;
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 32'h8);
    apb(1'b0, 8'h0c, 32'h0, rd);
    chk({e, rd[30:0]}, 32'h80000000);
    apb(1'b1, 8'h08, 32'hffff, rd);
    // parallel bus, straight binary then two's complement
    for (int f = 1; f >= 0; f--) begin
      apb(1'b1, 8'h00, f ? 32'h8 : 32'h0, rd);
      conv(16'h1234);
      repeat (3) @(negedge clk);
      chk({poe_n, pout}, {16'h0, fmt(16'h1234, f[0])});
      apb(1'b0, 8'h08, 32'h0, rd);
      chk(rd, fmt(16'h1234, f[0]));
    end
    // master mode, read after conversion
    for (int f = 1; f >= 0; f--) begin
      apb(1'b1, 8'h00, f ? 32'h9 : 32'h1, rd);
      fork
        conv(16'ha5c3);
        cap_int(v);
      join
      chk(v, fmt(16'ha5c3, f[0]));
      chk(poe_n[9:7], 3'b001);
      repeat (12) @(posedge clk);
    end
    // read during conversion sends the previous word
    rm <= 1'b1;
    repeat (6) @(posedge clk);
    fork
      conv(16'h5a3c);
      cap_int(v);
    join
    chk(v, 16'h25c3);
    repeat (140) @(posedge clk);
    // slave mode, both clock polarities, chained word behind
    for (int i = 0; i < 2; i++) begin
      inv <= i[0];
      ext_md <= 1'b1;
      apb(1'b1, 8'h00, 32'hb | (i << 2), rd);
      conv(16'hc35a);
      repeat (4) @(posedge clk);
      u_arop_host_model.run(16'h96e1, cap);
      chk(cap, 32'hc35a96e1);
      chk(poe_n[9], 1'b1);
    end
    stop_test;
  end
  // hang guard, far beyond the expected run
  initial begin
    #1000000;
    err_total++;
    stop_test;
  end
endmodule
